// File: iox_pkg.sv
// package for the sixteen-bit serial port expander
package iox_pkg;
  localparam logic [6:0] IOX_ADDR_BASE = 7'h74; // upper address bits
  localparam logic [7:0] IOX_REG_IN0 = 8'h00;
  localparam logic [7:0] IOX_REG_IN1 = 8'h01;
  localparam logic [7:0] IOX_REG_OUT0 = 8'h02;
  localparam logic [7:0] IOX_REG_OUT1 = 8'h03;
  localparam logic [7:0] IOX_REG_POL0 = 8'h04;
  localparam logic [7:0] IOX_REG_POL1 = 8'h05;
  localparam logic [7:0] IOX_REG_CFG0 = 8'h06;
  localparam logic [7:0] IOX_REG_CFG1 = 8'h07;
  localparam logic [7:0] IOX_REG_DRV0 = 8'h40; // 40h..43h drive
  localparam logic [7:0] IOX_REG_LAT0 = 8'h44;
  localparam logic [7:0] IOX_REG_LAT1 = 8'h45;
  localparam logic [7:0] IOX_REG_PEN0 = 8'h46;
  localparam logic [7:0] IOX_REG_PEN1 = 8'h47;
  localparam logic [7:0] IOX_REG_PSEL0 = 8'h48;
  localparam logic [7:0] IOX_REG_PSEL1 = 8'h49;
  localparam logic [7:0] IOX_REG_MSK0 = 8'h4a;
  localparam logic [7:0] IOX_REG_MSK1 = 8'h4b;
  localparam logic [7:0] IOX_REG_IST0 = 8'h4c;
  localparam logic [7:0] IOX_REG_IST1 = 8'h4d;
  localparam logic [7:0] IOX_REG_OCFG = 8'h4f;
  localparam logic [15:0] IOX_RST_OUT = 16'hffff;
  localparam logic [15:0] IOX_RST_POL = 16'h0000;
  localparam logic [15:0] IOX_RST_CFG = 16'hffff;
  localparam logic [31:0] IOX_RST_DRV = 32'hffffffff;
  localparam logic [15:0] IOX_RST_LAT = 16'h0000;
  localparam logic [15:0] IOX_RST_PEN = 16'h0000;
  localparam logic [15:0] IOX_RST_PSEL = 16'hffff;
  localparam logic [15:0] IOX_RST_MSK = 16'hffff;
  localparam logic [1:0] IOX_RST_OCFG = 2'h0;
  localparam int IOX_CLK_HZ = 25000000;
  localparam int IOX_SCL_MAX_HZ = 400000;
  // fewest system cycles per link clock period at top rate
  localparam int IOX_SCL_CYC = IOX_CLK_HZ / IOX_SCL_MAX_HZ;
  // per-pin and per-bank analogue controls handed to the pad ring
  typedef struct packed {
    logic [31:0] drive;   // two bits per pin
    logic [15:0] pull_en;
    logic [15:0] pull_up;
    logic [1:0] open_drain; // one per bank
  } iox_pad_s;
  typedef enum logic [4:0] {
    IOX_IDLE = 5'h01,
    IOX_ADDR = 5'h02,
    IOX_WDAT = 5'h04,
    IOX_RDAT = 5'h08,
    IOX_ACK = 5'h10
  } iox_state_e;
endpackage

// File: iox_expander.sv
// serial slave, register set and pin logic of the port expander
`timescale 1ns/10ps
// Function
// - interrupt when pin differs from input register
// - all interrupts masked after reset
// - power-on reset loads defaults, idles machine
// - low reset pin holds registers and machine
// - two select pins set low address bits
// - all pins inputs, undriven after reset
// - slave handles link clock up to 400kHz
// - bank selects push-pull or open-drain
// - read-only status shows interrupting pin
// - per-pin drive strength, four levels
// - latched change held until input read
// - per-pin pull resistor enable
// - per-pin pull up or down select
// - mask bit stops pin interrupting
// - interrupt open-drain, low while pending
// - eight-bit pairs: config, input, output, polarity
// - pin n maps to bit n of port
// - command byte sets register pointer
// - config one input, zero output
// - polarity one inverts input value
// - input reflects pins, writes ignored
module iox_expander #(
  parameter int PINS = 16
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,          // active-low reset pin
  input wire logic addr_sel_bit0,
  input wire logic addr_sel_bit1,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [PINS-1:0] pin_in,
  output logic [PINS-1:0] pin_out,
  output logic [PINS-1:0] pin_oe,
  output iox_pkg::iox_pad_s pad_ctl,
  output logic int_n_out,
  output logic int_n_oe
);
  import iox_pkg::*;

  // two-stage synchronisers for every outside input
  logic [2:0] scl_s, sda_s, rn_s;
  logic [PINS-1:0] pin_s1, pin_s2;
  logic [1:0] as_s1, as_s2; // address select pins, static but off-domain
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      rn_s <= 3'h0;
      pin_s1 <= '0;
      pin_s2 <= '0;
      as_s1 <= 2'h0;
      as_s2 <= 2'h0;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      rn_s <= {rn_s[1:0], reset_n};
      pin_s1 <= pin_in;
      pin_s2 <= pin_s1;
      as_s1 <= {addr_sel_bit1, addr_sel_bit0};
      as_s2 <= as_s1;
    end
  end
  // stage 2 and 3 feed logic; stage 1 only feeds stage 2
  wire hold = ~rn_s[1];
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire start_c = scl_s[1] & sda_s[2] & ~sda_s[1];
  wire stop_c = scl_s[1] & ~sda_s[2] & sda_s[1];
  // registers
  logic [15:0] out_r, pol_r, cfg_r, lat_r, pen_r, psel_r, msk_r;
  logic [31:0] drv_r;
  logic [1:0] ocfg_r;
  logic [15:0] in_r;     // input port register
  logic [15:0] ist_r;    // interrupt status
  logic [7:0] ptr_r;
  iox_state_e st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r;
  logic rw_r, first_r, ack_ok_r, sda_oe_r, sda_out_r, mack_r;

  // effective input value after polarity inversion
  wire [15:0] pin_val = pin_s2 ^ pol_r;
  wire [15:0] diff = pin_val ^ in_r;
  // read of input register clears latch and interrupt (byte granularity)
  logic rd_in0, rd_in1;
  wire [15:0] rd_in = {{8{rd_in1}}, {8{rd_in0}}};
  // latched bits keep their captured value until read
  wire [15:0] lat_keep = lat_r & ist_r & ~rd_in;
  // unmasked plain bits keep the last read level as the reference
  wire [15:0] ref_keep = ~msk_r & ~lat_r & ~rd_in;
  wire [15:0] in_keep = lat_keep | ref_keep;
  wire [15:0] in_nxt_w = (in_keep & in_r) | (~in_keep & pin_val);
  // what a read returns: captured value for pending latches, else live
  wire [15:0] in_view = (lat_r & ist_r & in_r)
    | (~(lat_r & ist_r) & pin_val);
  // register read mux
  function automatic logic [7:0] rd_byte(input logic [7:0] a);
    case (a)
      IOX_REG_IN0: rd_byte = in_view[7:0];
      IOX_REG_IN1: rd_byte = in_view[15:8];
      IOX_REG_OUT0: rd_byte = out_r[7:0];
      IOX_REG_OUT1: rd_byte = out_r[15:8];
      IOX_REG_POL0: rd_byte = pol_r[7:0];
      IOX_REG_POL1: rd_byte = pol_r[15:8];
      IOX_REG_CFG0: rd_byte = cfg_r[7:0];
      IOX_REG_CFG1: rd_byte = cfg_r[15:8];
      8'h40: rd_byte = drv_r[7:0];
      8'h41: rd_byte = drv_r[15:8];
      8'h42: rd_byte = drv_r[23:16];
      8'h43: rd_byte = drv_r[31:24];
      IOX_REG_LAT0: rd_byte = lat_r[7:0];
      IOX_REG_LAT1: rd_byte = lat_r[15:8];
      IOX_REG_PEN0: rd_byte = pen_r[7:0];
      IOX_REG_PEN1: rd_byte = pen_r[15:8];
      IOX_REG_PSEL0: rd_byte = psel_r[7:0];
      IOX_REG_PSEL1: rd_byte = psel_r[15:8];
      IOX_REG_MSK0: rd_byte = msk_r[7:0];
      IOX_REG_MSK1: rd_byte = msk_r[15:8];
      IOX_REG_IST0: rd_byte = ist_r[7:0];
      IOX_REG_IST1: rd_byte = ist_r[15:8];
      IOX_REG_OCFG: rd_byte = {6'h00, ocfg_r};
      default: rd_byte = 8'h00;
    endcase
  endfunction

  // pointer advance within a pair, as the pair protocol expects
  function automatic logic [7:0] ptr_inc(input logic [7:0] a);
    ptr_inc = {a[7:1], ~a[0]};
  endfunction

  // own address: fixed upper bits plus select pins
  wire [6:0] my_addr = {IOX_ADDR_BASE[6:2], as_s2};
  // byte at the pointer and at the next pointer, for read launches
  wire [7:0] rd_cur = rd_byte(ptr_r);
  wire [7:0] rd_nx = rd_byte(ptr_inc(ptr_r));
  wire byte_done = scl_rise & (bit_r == 4'h7);
  wire [7:0] sh_nxt = {sh_r[6:0], sda_s[1]};
  wire wr_stb = (st_r == IOX_WDAT) & byte_done & ~first_r;
  wire [7:0] wa = ptr_r;

  // serial slave machine: sampled on link clock edges
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_r <= IOX_IDLE;
      sh_r <= 8'h00;
      bit_r <= 4'h0;
      rw_r <= 1'b0;
      first_r <= 1'b0;
      ack_ok_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b1;
      mack_r <= 1'b0;
      ptr_r <= 8'h00;
      rd_in0 <= 1'b0;
      rd_in1 <= 1'b0;
    end else if (hold) begin
      st_r <= IOX_IDLE;
      sda_oe_r <= 1'b0;
      bit_r <= 4'h0;
      rd_in0 <= 1'b0;
      rd_in1 <= 1'b0;
    end else begin
      rd_in0 <= 1'b0;
      rd_in1 <= 1'b0;
      if (stop_c) begin
        st_r <= IOX_IDLE;
        sda_oe_r <= 1'b0;
      end else if (start_c) begin
        st_r <= IOX_ADDR;
        bit_r <= 4'h0;
        sda_oe_r <= 1'b0;
      end else begin
        case (st_r)
          IOX_IDLE: sda_oe_r <= 1'b0;
          IOX_ADDR, IOX_WDAT: begin
            if (scl_rise) begin
              sh_r <= sh_nxt;
              bit_r <= bit_r + 4'h1;
            end
            if (byte_done) begin
              if (st_r == IOX_ADDR) begin
                ack_ok_r <= (sh_nxt[7:1] == my_addr);
                rw_r <= sh_nxt[0];
                first_r <= ~sh_nxt[0];
              end else begin
                ack_ok_r <= 1'b1;
                first_r <= 1'b0;
                if (first_r) ptr_r <= sh_nxt;
                else ptr_r <= ptr_inc(ptr_r);
              end
              st_r <= IOX_ACK;
            end
          end
          IOX_ACK: begin
            // drive ack after falling edge; after the next one release, or for a read drive the first data bit
            if (scl_fall & ~sda_oe_r & bit_r == 4'h8) begin
              sda_oe_r <= ack_ok_r;
              sda_out_r <= 1'b0;
              bit_r <= 4'h9;
            end else if (scl_fall & bit_r == 4'h9) begin
              bit_r <= 4'h0;
              if (!ack_ok_r) st_r <= IOX_IDLE;
              else if (rw_r) begin
                st_r <= IOX_RDAT;
                sh_r <= rd_cur;
                sda_oe_r <= 1'b1;
                sda_out_r <= rd_cur[7];
                rd_in0 <= (ptr_r == IOX_REG_IN0);
                rd_in1 <= (ptr_r == IOX_REG_IN1);
              end else begin
                st_r <= IOX_WDAT;
                sda_oe_r <= 1'b0;
              end
            end
          end
          IOX_RDAT: begin
            if (scl_rise) begin
              bit_r <= bit_r + 4'h1;
              if (bit_r == 4'h8) mack_r <= ~sda_s[1];
            end
            if (scl_fall) begin
              if (bit_r < 4'h8) begin
                sh_r <= {sh_r[6:0], 1'b0};
                sda_out_r <= sh_r[6];
              end else if (bit_r == 4'h8) sda_oe_r <= 1'b0; // master acks
              else if (bit_r == 4'h9) begin
                bit_r <= 4'h0;
                if (mack_r) begin
                  ptr_r <= ptr_inc(ptr_r);
                  sh_r <= rd_nx;
                  sda_oe_r <= 1'b1;
                  sda_out_r <= rd_nx[7];
                  rd_in0 <= (ptr_inc(ptr_r) == IOX_REG_IN0);
                  rd_in1 <= (ptr_inc(ptr_r) == IOX_REG_IN1);
                end else st_r <= IOX_IDLE;
              end
            end
          end
          default: st_r <= IOX_IDLE;
        endcase
      end
    end
  end

  // configuration registers, written from the link
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      out_r <= IOX_RST_OUT;
      pol_r <= IOX_RST_POL;
      cfg_r <= IOX_RST_CFG;
      drv_r <= IOX_RST_DRV;
      lat_r <= IOX_RST_LAT;
      pen_r <= IOX_RST_PEN;
      psel_r <= IOX_RST_PSEL;
      msk_r <= IOX_RST_MSK;
      ocfg_r <= IOX_RST_OCFG;
    end else if (hold) begin
      out_r <= IOX_RST_OUT;
      pol_r <= IOX_RST_POL;
      cfg_r <= IOX_RST_CFG;
      drv_r <= IOX_RST_DRV;
      lat_r <= IOX_RST_LAT;
      pen_r <= IOX_RST_PEN;
      psel_r <= IOX_RST_PSEL;
      msk_r <= IOX_RST_MSK;
      ocfg_r <= IOX_RST_OCFG;
    end else if (wr_stb) begin
      // input and status addresses fall to default: writes ignored
      case (wa)
        IOX_REG_OUT0: out_r[7:0] <= sh_nxt;
        IOX_REG_OUT1: out_r[15:8] <= sh_nxt;
        IOX_REG_POL0: pol_r[7:0] <= sh_nxt;
        IOX_REG_POL1: pol_r[15:8] <= sh_nxt;
        IOX_REG_CFG0: cfg_r[7:0] <= sh_nxt;
        IOX_REG_CFG1: cfg_r[15:8] <= sh_nxt;
        8'h40: drv_r[7:0] <= sh_nxt;
        8'h41: drv_r[15:8] <= sh_nxt;
        8'h42: drv_r[23:16] <= sh_nxt;
        8'h43: drv_r[31:24] <= sh_nxt;
        IOX_REG_LAT0: lat_r[7:0] <= sh_nxt;
        IOX_REG_LAT1: lat_r[15:8] <= sh_nxt;
        IOX_REG_PEN0: pen_r[7:0] <= sh_nxt;
        IOX_REG_PEN1: pen_r[15:8] <= sh_nxt;
        IOX_REG_PSEL0: psel_r[7:0] <= sh_nxt;
        IOX_REG_PSEL1: psel_r[15:8] <= sh_nxt;
        IOX_REG_MSK0: msk_r[7:0] <= sh_nxt;
        IOX_REG_MSK1: msk_r[15:8] <= sh_nxt;
        IOX_REG_OCFG: ocfg_r <= sh_nxt[1:0];
        default: ;
      endcase
    end
  end

  // input register and interrupt status; read clear of a latched bit wins over a new change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      in_r <= 16'h0000;
      ist_r <= 16'h0000;
    end else if (hold) begin
      in_r <= pin_val;
      ist_r <= 16'h0000;
    end else begin
      in_r <= in_nxt_w;
      // status marks unmasked pins that changed; latched bits cleared on read, plain bits on match
      // a latched read reloads the reference, so its old mismatch is no set
      ist_r <= (diff & ~msk_r & ~(rd_in & lat_r))
        | (ist_r & ~rd_in & lat_r & ~msk_r)
        | (ist_r & diff & ~msk_r & ~lat_r);
    end
  end

  // pin drivers: push-pull drives both levels, open-drain only low
  wire [15:0] od_w = {{8{ocfg_r[1]}}, {8{ocfg_r[0]}}};
  assign pin_out = out_r;
  assign pin_oe = ~cfg_r & ~(od_w & out_r);
  assign pad_ctl = '{drive: drv_r, pull_en: pen_r, pull_up: psel_r,
    open_drain: ocfg_r};
  assign sda_out = sda_out_r;
  assign sda_oe = sda_oe_r & ~sda_out_r;
  // open-drain interrupt: only ever pulls low
  assign int_n_out = 1'b0;
  assign int_n_oe = |ist_r;

  a_int_masked: assert property (@(posedge clk) disable iff (rst)
    (msk_r == 16'hffff) |=> !int_n_oe)
    else $error("interrupt while all masked");
  a_cfg_input: assert property (@(posedge clk) disable iff (rst)
    (pin_oe & cfg_r) == 16'h0000)
    else $error("input pin driven");
  a_hold_idle: assert property (@(posedge clk) disable iff (rst)
    hold |=> (st_r == IOX_IDLE) && (cfg_r == IOX_RST_CFG))
    else $error("reset pin not holding");
  a_int_cause: assert property (@(posedge clk) disable iff (rst)
    (|(diff & ~msk_r & ~(rd_in & lat_r)) && !hold) |=> int_n_oe)
    else $error("change not flagged");
  a_sda_low: assert property (@(posedge clk) disable iff (rst)
    sda_oe |-> (st_r == IOX_ACK || st_r == IOX_RDAT))
    else $error("sda driven outside ack or read");
  a_od_bank: assert property (@(posedge clk) disable iff (rst)
    (pin_oe & pin_out & od_w) == 16'h0000)
    else $error("open-drain pin driven high");
endmodule // iox_expander

// File: iox_mst.sv
// link master model that runs the expander's serial pins
`timescale 1ns/10ps
module iox_mst (
  input wire logic clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_rel
);
  // both lines released at rest; the clock stands high between frames
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // wait n clocks, then move both lines together on that edge
  task automatic put(input int n, input logic c, input logic d);
    repeat (n) @(posedge clk);
    scl <= c;
    sda_rel <= d;
  endtask
  // one bit: eight clocks, the bench link clock period
  // low phase five clocks so the slave's late ack has settled
  // before we sample two clocks into the three clock high phase
  task automatic bit_io(input logic d, output logic q);
    put(2, 1'b0, d);
    put(3, 1'b1, d);
    repeat (2) @(posedge clk);
    q = sda_line;
    put(1, 1'b0, d);
  endtask
  // eight bits msb first, then the ninth bit (ack slot)
  task automatic byte_io(input logic [7:0] d, input logic last,
      output logic [7:0] q, output logic nine);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(last, nine);
  endtask
  // data falls while the clock is high
  task automatic start();
    put(1, 1'b1, 1'b1);
    put(4, 1'b1, 1'b0);
    put(4, 1'b0, 1'b0);
  endtask
  // data rises while the clock is high, then the bus rests
  task automatic stop();
    put(2, 1'b0, 1'b0);
    put(3, 1'b1, 1'b0);
    put(4, 1'b1, 1'b1);
    repeat (4) @(posedge clk);
  endtask
  // address, command byte, one data byte; ok only if all three acked
  task automatic wr_reg(input logic [6:0] a, input logic [7:0] p,
      input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic n0, n1, n2;
    start();
    byte_io({a, 1'b0}, 1'b1, q, n0);
    byte_io(p, 1'b1, q, n1);
    byte_io(d, 1'b1, q, n2);
    stop();
    ok = !(n0 | n1 | n2);
  endtask
  // set the pointer, then a fresh read frame ending with a nack
  task automatic rd_reg(input logic [6:0] a, input logic [7:0] p,
      output logic [7:0] q);
    logic [7:0] x;
    logic n;
    start();
    byte_io({a, 1'b0}, 1'b1, x, n);
    byte_io(p, 1'b1, x, n);
    stop();
    start();
    byte_io({a, 1'b1}, 1'b1, x, n);
    byte_io(8'hff, 1'b1, q, n);
    stop();
  endtask
endmodule // iox_mst

// File: tb.sv
// self-checking bench for the port expander
`timescale 1ns/10ps
module tb;
  import iox_pkg::*;
  localparam logic [6:0] ADR = IOX_ADDR_BASE; // select pins low
  localparam iox_pad_s DEF = '{IOX_RST_DRV, IOX_RST_PEN, IOX_RST_PSEL,
    IOX_RST_OCFG};
  // rows: pointer, byte written, byte read back
  localparam logic [23:0] ROWS [0:11] = '{24'h02a5a5, 24'h03c3c3,
    24'h040f0f, 24'h07f0f0, 24'h405555, 24'h478181, 24'h480f0f,
    24'h4f0101, 24'h00ff33, 24'h010053, 24'h4dff00, 24'h307700};
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reset_n = 1'b1;
  logic [1:0] asel = 2'h0;
  logic [15:0] pin_ext = 16'h5a3c; // level the board puts on the pins
  logic sda_out, sda_oe, int_n_out, int_n_oe, scl, sda_rel, sda_line, ok;
  logic [15:0] pin_out, pin_oe, pins;
  logic [7:0] rv;
  iox_pad_s pad_ctl;
  int failures = 0;
  int n_compared = 0;
  // wired-and data line with pull-up; driven pins override the board
  assign sda_line = sda_rel & ~(sda_oe & ~sda_out);
  assign pins = (pin_oe & pin_out) | (~pin_oe & pin_ext);
  always #20 clk = ~clk;
  iox_mst i_mst (.clk(clk), .sda_line(sda_line), .scl(scl),
    .sda_rel(sda_rel));
  iox_expander i_dut (.clk(clk), .rst(rst), .reset_n(reset_n),
    .addr_sel_bit0(asel[0]), .addr_sel_bit1(asel[1]), .scl_in(scl),
    .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .pin_in(pins), .pin_out(pin_out), .pin_oe(pin_oe),
    .pad_ctl(pad_ctl), .int_n_out(int_n_out), .int_n_oe(int_n_oe));
  // one comparison, counted; wide enough for the pad struct
  task automatic chk(input logic [65:0] got, input logic [65:0] exp,
      input string what);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got,
        exp);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    i_mst.wr_reg(ADR, p, d, ok);
    chk(ok, 1'b1, "write not acked");
  endtask
  task automatic rd(input logic [7:0] p);
    i_mst.rd_reg(ADR, p, rv);
  endtask
  // toggle board pins, then give the synchronisers time to settle
  task automatic flip(input logic [15:0] m);
    @(posedge clk);
    pin_ext <= pin_ext ^ m;
    repeat (10) @(posedge clk);
  endtask
  task automatic end_of_test();
    if (failures == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // watchdog: the sequence needs well under a millisecond
  initial begin
    #1500000;
    failures++;
    end_of_test();
  end
  // main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    chk(pin_oe, 16'h0, "pins driven");
    chk(pad_ctl, DEF, "pad defaults");
    chk(int_n_oe, 1'b0, "int at reset");
    foreach (ROWS[i]) begin
      wr(ROWS[i][23:16], ROWS[i][15:8]);
      rd(ROWS[i][23:16]);
      chk(rv, ROWS[i][7:0], "read back");
    end
    chk({pin_out[15:8], pin_oe}, 24'hc30f00, "bank1 out");
    chk(pad_ctl.drive[7:0], 8'h55, "drive");
    chk({pad_ctl.pull_en, pad_ctl.pull_up}, 32'h8100ff0f, "pull");
    chk(pad_ctl.open_drain, 2'h1, "stage");
    wr(IOX_REG_CFG0, 8'h00);
    chk(pin_oe, 16'h0f5a, "open drain");
    // reset pin mid-run puts everything back
    reset_n <= 1'b0;
    repeat (6) @(posedge clk);
    chk(pin_oe, 16'h0, "held by reset");
    reset_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk(pad_ctl, DEF, "defaults back");
    // interrupt: masked, unmasked, cleared, latched
    flip(16'h0001);
    chk(int_n_oe, 1'b0, "masked at reset");
    rd(IOX_REG_IN0);
    wr(IOX_REG_MSK0, 8'hfe);
    flip(16'h0002);
    chk(int_n_oe, 1'b0, "masked pin");
    rd(IOX_REG_IN0);
    flip(16'h0001);
    chk({int_n_oe, int_n_out}, 2'h2, "int low");
    rd(IOX_REG_IST0);
    chk(rv, 8'h01, "status");
    flip(16'h0001);
    chk(int_n_oe, 1'b0, "int cleared");
    wr(IOX_REG_LAT0, 8'h01);
    flip(16'h0001);
    flip(16'h0001);
    chk(int_n_oe, 1'b1, "latched int");
    rd(IOX_REG_IN0);
    chk(rv, 8'h3e, "latched value");
    repeat (10) @(posedge clk);
    chk(int_n_oe, 1'b0, "read clears");
    // each select setting answers its own address, not the complemented one
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      asel <= i[1:0];
      i_mst.wr_reg({ADR[6:2], i[1:0]}, IOX_REG_POL0, 8'h00, ok);
      chk(ok, 1'b1, "own address");
      i_mst.wr_reg({ADR[6:2], ~i[1:0]}, IOX_REG_POL0, 8'h00, ok);
      chk(ok, 1'b0, "other address");
    end
    end_of_test();
  end
endmodule // tb
